// >>> tfc_feature_event_ctrl.sv
// Test and feature control register with event flags and masks.
// Assumes the MAC, receiver and buffer manager act on the control outputs
// and pulse the event inputs for one cycle on the same clock.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module tfc_feature_event_ctrl #(
    parameter int FRAME_LEN_W = 7
) (
    input  wire logic                             clock_i,
    input  wire logic                             sys_rst_i,
    input  wire logic                             soft_rst_i,
    input  wire logic                             stop_cmd_i,
    input  wire logic [tfc_pkg::TFC_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [tfc_pkg::TFC_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    output logic      [tfc_pkg::TFC_DATA_W-1:0]   reg_rdata_o,
    input  wire logic                             global_irq_enable_i,
    input  wire logic                             transmitter_on_i,
    input  wire logic                             transmit_demand_i,
    input  wire logic                             rx_activity_i,
    input  wire logic                             missed_frame_wrap_i,
    input  wire logic                             rx_collision_wrap_i,
    input  wire logic                             tx_begin_i,
    input  wire logic                             tx_check_seq_disable_i,
    input  wire logic                             per_frame_check_seq_add_i,
    input  wire logic [FRAME_LEN_W-1:0]           tx_frame_len_i,
    output logic                                  tx_poll_disable_o,
    output logic                                  tx_poll_req_o,
    output logic                                  auto_pad_enable_o,
    output logic                                  tx_pad_needed_o,
    output logic                                  tx_fcs_append_o,
    output logic                                  auto_strip_enable_o,
    output logic                                  irq_summary_o
);
    // ====================================================================
    // Elaboration checks
    // A narrower length port could not tell a minimum frame from a runt.
    if (FRAME_LEN_W < $bits(tfc_pkg::TFC_MIN_FRAME_BYTES)) begin : g_len_chk
        $error("Frame length port narrower than the minimum frame count.");
    end

    // ====================================================================
    // Decode
    logic wr_hit;
    logic clr_all;
    logic [tfc_pkg::TFC_DATA_W-1:0] wd;
    assign wr_hit  = reg_wr_i &&
                     (reg_addr_i == tfc_pkg::TFC_ADDR_TEST_FEATURE_CONTROL);
    assign wd      = reg_wdata_i;
    // Stop clears the flags and the user command but not controls or masks.
    assign clr_all = sys_rst_i || soft_rst_i;

    logic legacy_res_r;
    logic tx_poll_disable_r;
    logic auto_pad_enable_r;
    logic auto_strip_enable_r;
    logic missed_frame_overflow_mask_r;
    logic rx_collision_overflow_mask_r;
    logic tx_begin_mask_r;
    logic missed_frame_overflow_flag_r;
    logic rx_collision_overflow_flag_r;
    logic tx_begin_flag_r;
    logic user_irq_command_r;
    logic user_irq_flag_r;

    // ====================================================================
    // Control bits and masks
    always_ff @(posedge clock_i) begin
        if (clr_all) begin
            legacy_res_r        <= tfc_pkg::TFC_CTRL_RESET;
            tx_poll_disable_r   <= tfc_pkg::TFC_CTRL_RESET;
            auto_pad_enable_r   <= tfc_pkg::TFC_CTRL_RESET;
            auto_strip_enable_r <= tfc_pkg::TFC_CTRL_RESET;
        end else if (wr_hit) begin
            legacy_res_r        <= wd[tfc_pkg::TFC_BIT_LEGACY_RES];
            tx_poll_disable_r   <= wd[tfc_pkg::TFC_BIT_TX_POLL_DISABLE];
            auto_pad_enable_r   <= wd[tfc_pkg::TFC_BIT_AUTO_PAD];
            auto_strip_enable_r <= wd[tfc_pkg::TFC_BIT_AUTO_STRIP];
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_all) begin
            missed_frame_overflow_mask_r <= tfc_pkg::TFC_MASK_RESET;
            rx_collision_overflow_mask_r <= tfc_pkg::TFC_MASK_RESET;
            tx_begin_mask_r              <= tfc_pkg::TFC_MASK_RESET;
        end else if (wr_hit) begin
            missed_frame_overflow_mask_r <= wd[tfc_pkg::TFC_BIT_MF_MASK];
            rx_collision_overflow_mask_r <= wd[tfc_pkg::TFC_BIT_RC_MASK];
            tx_begin_mask_r              <= wd[tfc_pkg::TFC_BIT_TXB_MASK];
        end
    end

    // ====================================================================
    // Event flags, write one to clear, set wins over clear
    always_ff @(posedge clock_i) begin
        if (clr_all || stop_cmd_i) begin
            missed_frame_overflow_flag_r <= tfc_pkg::TFC_FLAG_RESET;
        end else if (missed_frame_wrap_i) begin
            missed_frame_overflow_flag_r <= 1'b1;
        end else if (wr_hit && wd[tfc_pkg::TFC_BIT_MF_FLAG]) begin
            missed_frame_overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_all || stop_cmd_i) begin
            rx_collision_overflow_flag_r <= tfc_pkg::TFC_FLAG_RESET;
        end else if (rx_collision_wrap_i) begin
            rx_collision_overflow_flag_r <= 1'b1;
        end else if (wr_hit && wd[tfc_pkg::TFC_BIT_RC_FLAG]) begin
            rx_collision_overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (clr_all || stop_cmd_i) begin
            tx_begin_flag_r <= tfc_pkg::TFC_FLAG_RESET;
        end else if (tx_begin_i) begin
            tx_begin_flag_r <= 1'b1;
        end else if (wr_hit && wd[tfc_pkg::TFC_BIT_TXB_FLAG]) begin
            tx_begin_flag_r <= 1'b0;
        end
    end

    // ====================================================================
    // User interrupt: the flag follows the command one cycle later.
    logic user_clr;
    assign user_clr = wr_hit && wd[tfc_pkg::TFC_BIT_USER_FLAG];

    always_ff @(posedge clock_i) begin
        if (clr_all || stop_cmd_i) begin
            user_irq_command_r <= tfc_pkg::TFC_FLAG_RESET;
        end else if (user_clr) begin
            user_irq_command_r <= 1'b0;
        end else if (wr_hit && wd[tfc_pkg::TFC_BIT_USER_CMD]) begin
            user_irq_command_r <= 1'b1;
        end
    end

    // A command still pending keeps re-setting the flag, so the clearing
    // write drops the command in the same cycle and the flag stays clear after it.
    always_ff @(posedge clock_i) begin
        if (clr_all || stop_cmd_i) begin
            user_irq_flag_r <= tfc_pkg::TFC_FLAG_RESET;
        end else if (user_clr) begin
            user_irq_flag_r <= 1'b0;
        end else if (user_irq_command_r) begin
            user_irq_flag_r <= 1'b1;
        end
    end

    // ====================================================================
    // Interrupt summary
    // A masked flag still reads back; it only stops driving the summary.
    logic mf_irq;
    logic rc_irq;
    logic txb_irq;
    assign mf_irq  = missed_frame_overflow_flag_r &&
                     !missed_frame_overflow_mask_r;
    assign rc_irq  = rx_collision_overflow_flag_r &&
                     !rx_collision_overflow_mask_r;
    assign txb_irq = tx_begin_flag_r && !tx_begin_mask_r;
    assign irq_summary_o = global_irq_enable_i &&
        (mf_irq || rc_irq || txb_irq || user_irq_command_r);

    // ====================================================================
    // Feature outputs
    logic rx_seen_r;
    always_ff @(posedge clock_i) begin
        if (clr_all || !transmitter_on_i) begin
            rx_seen_r <= 1'b0;
        end else if (rx_activity_i) begin
            rx_seen_r <= 1'b1;
        end else if (rx_seen_r) begin
            rx_seen_r <= 1'b0;
        end
    end

    assign tx_poll_disable_o   = tx_poll_disable_r;
    assign auto_pad_enable_o   = auto_pad_enable_r;
    assign auto_strip_enable_o = auto_strip_enable_r;
    // Polling waits for the transmitter; manual demand works only while it is on.
    assign tx_poll_req_o = transmitter_on_i &&
        (!tx_poll_disable_r || transmit_demand_i || rx_seen_r);

    logic short_frame;
    assign short_frame     = tx_frame_len_i <
                             FRAME_LEN_W'(tfc_pkg::TFC_MIN_FRAME_BYTES);
    assign tx_pad_needed_o = auto_pad_enable_r && short_frame;
    // Auto pad forces the check sequence on short frames only.
    assign tx_fcs_append_o = (auto_pad_enable_r && short_frame) ||
        !tx_check_seq_disable_i || per_frame_check_seq_add_i;

    // ====================================================================
    // Read port
    logic [tfc_pkg::TFC_DATA_W-1:0] rd_word;
    always_comb begin
        rd_word = tfc_pkg::TFC_ZERO_WORD;
        rd_word[tfc_pkg::TFC_BIT_LEGACY_RES]      = legacy_res_r;
        rd_word[tfc_pkg::TFC_BIT_FIXED_ONE]       = 1'b1;
        rd_word[tfc_pkg::TFC_BIT_TX_POLL_DISABLE] = tx_poll_disable_r;
        rd_word[tfc_pkg::TFC_BIT_AUTO_PAD]        = auto_pad_enable_r;
        rd_word[tfc_pkg::TFC_BIT_AUTO_STRIP]      = auto_strip_enable_r;
        rd_word[tfc_pkg::TFC_BIT_MF_FLAG]  = missed_frame_overflow_flag_r;
        rd_word[tfc_pkg::TFC_BIT_MF_MASK]  = missed_frame_overflow_mask_r;
        rd_word[tfc_pkg::TFC_BIT_USER_CMD] = user_irq_command_r;
        rd_word[tfc_pkg::TFC_BIT_USER_FLAG] = user_irq_flag_r;
        rd_word[tfc_pkg::TFC_BIT_RC_FLAG]  = rx_collision_overflow_flag_r;
        rd_word[tfc_pkg::TFC_BIT_RC_MASK]  = rx_collision_overflow_mask_r;
        rd_word[tfc_pkg::TFC_BIT_TXB_FLAG] = tx_begin_flag_r;
        rd_word[tfc_pkg::TFC_BIT_TXB_MASK] = tx_begin_mask_r;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= tfc_pkg::TFC_ZERO_WORD;
        end else if (reg_rd_i &&
                     reg_addr_i == tfc_pkg::TFC_ADDR_TEST_FEATURE_CONTROL) begin
            reg_rdata_o <= rd_word;
        end else begin
            reg_rdata_o <= tfc_pkg::TFC_ZERO_WORD;
        end
    end
endmodule

`default_nettype wire

// >>> tfc_feature_event_ctrl_monitor.sv
// Port checker for the test and feature control register bank.
// Assumes one clock and a synchronous active-high hard reset.
`timescale 1ns/100ps
`default_nettype none
module tfc_feature_event_ctrl_monitor (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        soft_rst_i,
    input wire logic        stop_cmd_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        global_irq_enable_i,
    input wire logic        missed_frame_wrap_i,
    input wire logic [6:0]  tx_frame_len_i,
    input wire logic        tx_poll_disable_o,
    input wire logic        auto_pad_enable_o,
    input wire logic        tx_pad_needed_o,
    input wire logic        tx_fcs_append_o,
    input wire logic        auto_strip_enable_o,
    input wire logic        irq_summary_o
);
    // ====================================================================
    // Properties
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic hit_w;
    logic quiet_w;
    assign hit_w   = reg_addr_i == tfc_pkg::TFC_ADDR_TEST_FEATURE_CONTROL;
    assign quiet_w = !soft_rst_i && !stop_cmd_i;
    sequence s_unmask_mf; reg_wr_i && hit_w && !reg_wdata_i[8]; endsequence
    sequence s_mf_wrap; missed_frame_wrap_i && quiet_w; endsequence
    sequence s_user_cmd;
        reg_wr_i && hit_w && reg_wdata_i[7] && !reg_wdata_i[6] && quiet_w;
    endsequence
    property p_mf_irq;
        s_unmask_mf ##1 s_mf_wrap ##1 global_irq_enable_i |-> irq_summary_o;
    endproperty
    property p_rd; $past(reg_rd_i) |-> reg_rdata_o[14] == $past(hit_w)
        && reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[13] == 1'b0
        && reg_rdata_o[1:0] == 2'h0; endproperty
    property p_gate; !global_irq_enable_i |-> !irq_summary_o; endproperty
    property p_user; s_user_cmd ##1 global_irq_enable_i |-> irq_summary_o;
    endproperty
    property p_soft; soft_rst_i |=> !irq_summary_o && !tx_poll_disable_o
        && !auto_pad_enable_o && !auto_strip_enable_o; endproperty
    property p_stop; stop_cmd_i && !soft_rst_i && !reg_wr_i |=>
        !irq_summary_o && $stable(tx_poll_disable_o)
        && $stable(auto_pad_enable_o) && $stable(auto_strip_enable_o);
    endproperty
    property p_ctrl; reg_wr_i && hit_w && !soft_rst_i |=>
        {tx_poll_disable_o, auto_pad_enable_o, auto_strip_enable_o}
        == $past(reg_wdata_i[12:10]); endproperty
    // Only clearly short frames are judged, so the length convention
    // around the check sequence cannot make this fire falsely.
    property p_pad; auto_pad_enable_o && tx_frame_len_i < 7'h3C |->
        tx_pad_needed_o && tx_fcs_append_o; endproperty
    a_mf_irq: assert property (p_mf_irq)
        else $error("missed frame flag gave no interrupt");
    a_rd: assert property (p_rd)
        else $error("read data has wrong fixed or reserved bits");
    a_gate: assert property (p_gate)
        else $error("interrupt raised while globally disabled");
    a_user: assert property (p_user)
        else $error("user command gave no interrupt");
    a_soft: assert property (p_soft)
        else $error("soft reset left controls or interrupt set");
    a_stop: assert property (p_stop)
        else $error("stop disturbed controls or left interrupt");
    a_ctrl: assert property (p_ctrl)
        else $error("control bits differ from written value");
    a_pad: assert property (p_pad)
        else $error("short frame not padded with check sequence");
endmodule
bind tfc_feature_event_ctrl tfc_feature_event_ctrl_monitor u_mon (.*);
`default_nettype wire

// >>> tfc_feature_event_ctrl_tb.sv
// Self-checking bench for the test and feature control register bank.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tfc_feature_event_ctrl_tb;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        soft_rst_i = 1'b0;
    logic        stop_cmd_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        global_irq_enable_i = 1'b1;
    logic        transmitter_on_i = 1'b0;
    logic        rx_activity_i = 1'b0;
    logic        tx_check_seq_disable_i = 1'b1;
    logic        per_frame_check_seq_add_i = 1'b0;
    logic        want_tx = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [6:0]  tx_frame_len_i = 7'h14;
    logic [31:0] reg_rdata_o;
    logic        missed_frame_wrap_i, rx_collision_wrap_i, tx_begin_i;
    logic        transmit_demand_i, tx_poll_disable_o, tx_poll_req_o;
    logic        auto_pad_enable_o, tx_pad_needed_o, tx_fcs_append_o;
    logic        auto_strip_enable_o, irq_summary_o;
    logic [31:0] msk [3] = '{32'h00000100, 32'h00000010, 32'h00000004};
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    tfc_feature_event_ctrl u_tfc_feature_event_ctrl (.*);
    tfc_mac_model u_tfc_mac_model (
        .clock_i             (clock_i),
        .tx_poll_disable_i   (tx_poll_disable_o),
        .want_tx_i           (want_tx),
        .missed_frame_wrap_o (missed_frame_wrap_i),
        .rx_collision_wrap_o (rx_collision_wrap_i),
        .tx_begin_o          (tx_begin_i),
        .transmit_demand_o   (transmit_demand_i)
    );
    // ====================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] d);
        reg_addr_i <= 4'h4;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
        @(posedge clock_i);
    endtask
    // Port flags: poll, pad, fcs, poll off, pad on, strip on, irq.
    task automatic look(input logic [31:0] m, input logic [31:0] e);
        #1 chk({25'h0, tx_poll_req_o, tx_pad_needed_o, tx_fcs_append_o,
            tx_poll_disable_o, auto_pad_enable_o, auto_strip_enable_o,
            irq_summary_o} & m, e);
        @(posedge clock_i);
    endtask
    task automatic ctl(input logic st, input logic sr);
        stop_cmd_i <= st;
        soft_rst_i <= sr;
        @(posedge clock_i);
        stop_cmd_i <= 1'b0;
        soft_rst_i <= 1'b0;
    endtask
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ====================================================================
    // Clock, watchdog and sequence
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(4'h4, 32'h00004114);
        rd(4'h3, 32'h00000000);
        wr(32'h0000DD14);
        rd(4'h4, 32'h0000DD14);
        look(32'h0E, 32'h0E);
        look(32'h30, 32'h30);
        tx_frame_len_i <= 7'h64;
        rx_activity_i <= 1'b1;
        look(32'h70, 32'h00);
        rx_activity_i <= 1'b0;
        transmitter_on_i <= 1'b1;
        look(32'h40, 32'h00);
        want_tx <= 1'b1;
        look(32'h40, 32'h40);
        want_tx <= 1'b0;
        per_frame_check_seq_add_i <= 1'b1;
        rx_activity_i <= 1'b1;
        look(32'h50, 32'h10);
        rx_activity_i <= 1'b0;
        tx_check_seq_disable_i <= 1'b0;
        per_frame_check_seq_add_i <= 1'b0;
        look(32'h50, 32'h50);
        look(32'h40, 32'h00);
        ctl(1'b1, 1'b0);
        rd(4'h4, 32'h0000DD14);
        ctl(1'b0, 1'b1);
        rd(4'h4, 32'h00004114);
        look(32'h70, 32'h50);
        for (int k = 0; k < 3; k++) begin
            wr(msk[k]);
            u_tfc_mac_model.fire(k);
            look(32'h01, 32'h00);
            rd(4'h4, 32'h00004000 | msk[k] | msk[k] << 1);
            wr(32'h00000000);
            look(32'h01, 32'h01);
            fork
                wr(msk[k] << 1);
                u_tfc_mac_model.fire(k);
            join
            look(32'h01, 32'h01);
            wr(msk[k] << 1);
            look(32'h01, 32'h00);
            wr(32'h00000000);
            u_tfc_mac_model.fire(k);
            look(32'h01, 32'h01);
            ctl(1'b1, 1'b0);
            rd(4'h4, 32'h00004000);
        end
        wr(32'h00000080);
        look(32'h01, 32'h01);
        global_irq_enable_i <= 1'b0;
        look(32'h01, 32'h00);
        global_irq_enable_i <= 1'b1;
        rd(4'h4, 32'h000040C0);
        wr(32'h00000040);
        look(32'h01, 32'h00);
        rd(4'h4, 32'h00004000);
        wr(32'h00000080);
        ctl(1'b1, 1'b0);
        rd(4'h4, 32'h00004000);
        stop_test();
    end
endmodule
`default_nettype wire

// >>> tfc_mac_model.sv
// Behavioural model of the MAC and DMA side feeding the register bank.
// Assumes events are one-cycle pulses launched just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module tfc_mac_model (
    input  wire logic clock_i,
    input  wire logic tx_poll_disable_i,
    input  wire logic want_tx_i,
    output logic      missed_frame_wrap_o,
    output logic      rx_collision_wrap_o,
    output logic      tx_begin_o,
    output logic      transmit_demand_o
);
    // ====================================================================
    // Event pulses
    logic [2:0] ev_r = 3'h0;
    assign {tx_begin_o, rx_collision_wrap_o, missed_frame_wrap_o} = ev_r;
    // Manual polls are asked for only while automatic polling is off.
    assign transmit_demand_o = want_tx_i && tx_poll_disable_i;
    task automatic fire(input int k);
        ev_r <= 3'h1 << k;
        @(posedge clock_i);
        ev_r <= 3'h0;
    endtask
endmodule
`default_nettype wire

// >>> tfc_pkg.sv
// Package for the test and feature control register bank.
// Assumes a plain register port with one-cycle strobes on one clock.
package tfc_pkg;
    // ====================================================================
    // Register map
    localparam logic [3:0]  TFC_ADDR_TEST_FEATURE_CONTROL = 4'h4;
    localparam int          TFC_ADDR_W                    = 4;
    localparam int          TFC_DATA_W                    = 32;

    // ====================================================================
    // Field positions
    localparam int TFC_BIT_LEGACY_RES      = 15;
    localparam int TFC_BIT_FIXED_ONE       = 14;
    localparam int TFC_BIT_TX_POLL_DISABLE = 12;
    localparam int TFC_BIT_AUTO_PAD        = 11;
    localparam int TFC_BIT_AUTO_STRIP      = 10;
    localparam int TFC_BIT_MF_FLAG         = 9;
    localparam int TFC_BIT_MF_MASK         = 8;
    localparam int TFC_BIT_USER_CMD        = 7;
    localparam int TFC_BIT_USER_FLAG       = 6;
    localparam int TFC_BIT_RC_FLAG         = 5;
    localparam int TFC_BIT_RC_MASK         = 4;
    localparam int TFC_BIT_TXB_FLAG        = 3;
    localparam int TFC_BIT_TXB_MASK        = 2;

    // ====================================================================
    // Reset values and frame figures
    localparam logic        TFC_MASK_RESET   = 1'b1;
    localparam logic        TFC_CTRL_RESET   = 1'b0;
    localparam logic        TFC_FLAG_RESET   = 1'b0;
    localparam logic [6:0]  TFC_MIN_FRAME_BYTES = 7'h40;
    localparam logic [31:0] TFC_ZERO_WORD    = 32'h00000000;
endpackage
